/* File: gp8_regs.svh */
/*
 * register offsets, reset values and pin positions of the 8-bit port.
 * assumes a classic wishbone slave with 16-bit byte addresses.
 */
`ifndef GP8_REGS_SVH
`define GP8_REGS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define GP8_ADDR_LATCH    16'hFFDB
`define GP8_ADDR_DIR      16'hFFEB
`define GP8_LATCH_RESET   8'h00
`define GP8_DIR_RESET     8'h00
`define GP8_DIR_READBACK  8'hFF
`define GP8_UNMAPPED_READ 8'h00
`define GP8_PINS_OFF      8'h00

// ---------------------------------------------------------------
// pin positions
// ---------------------------------------------------------------
`define GP8_PIN_CLK       0
`define GP8_PIN_CMP_A     1
`define GP8_PIN_CMP_B     2
`define GP8_PIN_CAP_A     3
`define GP8_PIN_CAP_B     4
`define GP8_PIN_CAP_C     5
`define GP8_PIN_CAP_D     6

`endif

/* File: gp8_pkg.sv */
/*
 * types shared by the 8-bit port.
 * assumes the timer supplies compare values and pin enables.
 */
`default_nettype none
package gp8_pkg;
    typedef enum logic [1:0] {
        GP8_RUN,
        GP8_HOLD,
        GP8_FLOAT
    } gp8_mode_t;

    typedef struct packed {
        logic compare_a_pin_enable;
        logic compare_b_pin_enable;
        logic timer_compare_out_a;
        logic timer_compare_out_b;
    } gp8_tmr_out_t;

    typedef struct packed {
        logic timer_capture_in_a;
        logic timer_capture_in_b;
        logic timer_capture_in_c;
        logic timer_capture_in_d;
        logic timer_external_count_clock;
    } gp8_tmr_in_t;
endpackage
`default_nettype wire

/* File: gp8_port.sv */
/*
 * 8-bit general purpose port with timer compare and capture pins.
 * assumes a classic wishbone master, one clock, and the timer block
 * plus the power manager outside, supplying overrides and mode.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gp8_regs.svh"

module gp8_port (
    input  wire logic                 clk_i,      // 20 MHz system clock
    input  wire logic                 rst_i,      // synchronous reset, high
    input  wire logic                 cyc_i,      // wishbone cycle
    input  wire logic                 stb_i,      // wishbone strobe
    input  wire logic                 we_i,       // wishbone write
    input  wire logic [15:0]          adr_i,      // wishbone byte address
    input  wire logic [0:0]           sel_i,      // wishbone byte select
    input  wire logic [7:0]           dat_i,      // wishbone write data
    output logic      [7:0]           dat_o,      // wishbone read data
    output logic                      ack_o,      // wishbone acknowledge
    input  wire gp8_pkg::gp8_mode_t   mode_i,     // power mode of the chip
    input  wire gp8_pkg::gp8_tmr_out_t tmr_i,     // timer overrides
    output gp8_pkg::gp8_tmr_in_t      tmr_o,      // timer capture/clock
    input  wire logic [7:0]           pin_i,      // pin levels
    output logic      [7:0]           pin_o,      // pin drive values
    output logic      [7:0]           pin_oe_o    // pin drive enables
);

    logic [7:0] port_output_latch_reg;
    logic [7:0] port_direction_control_reg;
    logic [7:0] drv_next;
    logic [7:0] oe_next;
    logic [7:0] rd_next;
    logic       req;
    logic       wr_ok;

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    // ack in the cycle after the request, dropped the cycle after
    // !ack_o keeps a request that is still held from being taken twice
    assign req   = cyc_i && stb_i && !ack_o;
    assign wr_ok = req && we_i && sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_output_latch_reg <= `GP8_LATCH_RESET;
        end else if (wr_ok && adr_i == `GP8_ADDR_LATCH) begin
            port_output_latch_reg <= dat_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_direction_control_reg <= `GP8_DIR_RESET;
        end else if (wr_ok && adr_i == `GP8_ADDR_DIR) begin
            port_direction_control_reg <= dat_i;
        end
    end

    // read mux
    // pins are taken as synchronous: no extra stage, reads see the current level
    always_comb begin
        case (adr_i)
            `GP8_ADDR_LATCH: rd_next = (port_direction_control_reg & port_output_latch_reg)
                                     | (~port_direction_control_reg & pin_i);
            `GP8_ADDR_DIR:   rd_next = `GP8_DIR_READBACK;
            default:         rd_next = `GP8_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= `GP8_UNMAPPED_READ;
        end else if (req && !we_i) begin
            dat_o <= rd_next;
        end
    end

    // ---------------------------------------------------------------
    // pin drivers
    // ---------------------------------------------------------------
    always_comb begin
        oe_next  = port_direction_control_reg;
        drv_next = port_output_latch_reg;
        if (tmr_i.compare_a_pin_enable) begin
            oe_next[`GP8_PIN_CMP_A]  = 1'b1;
            drv_next[`GP8_PIN_CMP_A] = tmr_i.timer_compare_out_a;
        end
        if (tmr_i.compare_b_pin_enable) begin
            oe_next[`GP8_PIN_CMP_B]  = 1'b1;
            drv_next[`GP8_PIN_CMP_B] = tmr_i.timer_compare_out_b;
        end
    end

    // registered pins so sleep can simply freeze them
    // standby drops the enables only, so pin_o keeps its last value until wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o    <= `GP8_PINS_OFF;
            pin_oe_o <= `GP8_PINS_OFF;
        end else begin
            case (mode_i)
                gp8_pkg::GP8_RUN: begin
                    pin_o    <= drv_next;
                    pin_oe_o <= oe_next;
                end
                gp8_pkg::GP8_HOLD: begin
                    pin_o    <= pin_o;
                    pin_oe_o <= pin_oe_o;
                end
                gp8_pkg::GP8_FLOAT: begin
                    pin_o    <= pin_o;
                    pin_oe_o <= `GP8_PINS_OFF;
                end
                default: begin
                    pin_o    <= pin_o;
                    pin_oe_o <= `GP8_PINS_OFF;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // timer inputs
    // ---------------------------------------------------------------
    // capture and clock feed
    always_comb begin
        tmr_o.timer_capture_in_a         = pin_i[`GP8_PIN_CAP_A];
        tmr_o.timer_capture_in_b         = pin_i[`GP8_PIN_CAP_B];
        tmr_o.timer_capture_in_c         = pin_i[`GP8_PIN_CAP_C];
        tmr_o.timer_capture_in_d         = pin_i[`GP8_PIN_CAP_D];
        tmr_o.timer_external_count_clock = pin_i[`GP8_PIN_CLK];
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ok && adr_i == `GP8_ADDR_LATCH |=> port_output_latch_reg == $past(dat_i))
        else $error("latch write lost");
    a_read_output: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && adr_i == `GP8_ADDR_LATCH |=>
        ((dat_o ^ port_output_latch_reg) & port_direction_control_reg) == 8'h00)
        else $error("output bit read wrong");
    a_read_input: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && adr_i == `GP8_ADDR_LATCH |=>
        ((dat_o ^ $past(pin_i)) & ~port_direction_control_reg) == 8'h00)
        else $error("input bit read wrong");
    a_dir_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_i == gp8_pkg::GP8_RUN && !tmr_i.compare_a_pin_enable && !tmr_i.compare_b_pin_enable
        |=> pin_oe_o == $past(port_direction_control_reg))
        else $error("driver not per direction");
    a_reset_clear: assert property (@(posedge clk_i)
        rst_i |=> port_output_latch_reg == `GP8_LATCH_RESET
        && port_direction_control_reg == `GP8_DIR_RESET && pin_oe_o == `GP8_PINS_OFF)
        else $error("reset did not clear");
    a_dir_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && adr_i == `GP8_ADDR_DIR |=> dat_o == `GP8_DIR_READBACK && ack_o)
        else $error("direction read not ones");
    a_cmp_b_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_i == gp8_pkg::GP8_RUN && tmr_i.compare_b_pin_enable |=>
        pin_oe_o[`GP8_PIN_CMP_B] && pin_o[`GP8_PIN_CMP_B] == $past(tmr_i.timer_compare_out_b))
        else $error("compare b not on pin");
    a_cmp_a_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_i == gp8_pkg::GP8_RUN && tmr_i.compare_a_pin_enable |=>
        pin_oe_o[`GP8_PIN_CMP_A] && pin_o[`GP8_PIN_CMP_A] == $past(tmr_i.timer_compare_out_a))
        else $error("compare a not on pin");
    a_capture_feed: assert property (@(posedge clk_i) disable iff (rst_i)
        tmr_o.timer_capture_in_a == pin_i[`GP8_PIN_CAP_A]
        && tmr_o.timer_capture_in_b == pin_i[`GP8_PIN_CAP_B]
        && tmr_o.timer_capture_in_c == pin_i[`GP8_PIN_CAP_C]
        && tmr_o.timer_capture_in_d == pin_i[`GP8_PIN_CAP_D]
        && tmr_o.timer_external_count_clock == pin_i[`GP8_PIN_CLK])
        else $error("timer inputs not fed");
    a_mode_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_i == gp8_pkg::GP8_HOLD |=> pin_o == $past(pin_o) && pin_oe_o == $past(pin_oe_o))
        else $error("pins not held in sleep");
    a_float_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_i == gp8_pkg::GP8_FLOAT |=> pin_oe_o == 8'h00)
        else $error("pins not floated in standby");
    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o)
        else $error("request not acked");
    a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && adr_i != `GP8_ADDR_LATCH && adr_i != `GP8_ADDR_DIR
        |=> dat_o == `GP8_UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_read_held: assert property (@(posedge clk_i) disable iff (rst_i)
        !(req && !we_i) |=> $stable(dat_o))
        else $error("read data moved");

endmodule
`default_nettype wire

/* File: gp8_board.sv */
/* board model: resolves each pin from the port drive and the board level.
   assumes the bench supplies the board levels for undriven pins. */
`timescale 1ns/10ps
`default_nettype none
module gp8_board (
    input  wire logic [7:0] pin_o,    // port drive values
    input  wire logic [7:0] pin_oe_o, // port drive enables
    input  wire logic [7:0] ext_i,    // board level when undriven
    output logic      [7:0] pin_i     // resolved level
);
    assign pin_i = (pin_o & pin_oe_o) | (ext_i & ~pin_oe_o);
endmodule
`default_nettype wire

/* File: gp8_port_bench.sv */
/* self-checking bench of gp8_port with an integer model.
   assumes gp8_board as far side and the timer driven by the bench. */
`timescale 1ns/10ps
`default_nettype none
`include "gp8_regs.svh"
module gp8_port_bench;
    logic                   clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [15:0]            adr_i, r;
    logic [0:0]             sel_i;
    logic [7:0]             dat_i, dat_o, pin_o, pin_oe_o, pin_i, ext, q, e;
    gp8_pkg::gp8_mode_t     mode_i;
    gp8_pkg::gp8_tmr_out_t  tmr_i;
    gp8_pkg::gp8_tmr_in_t   tmr_o;
    int                     fails, total_checks, lat_m, dir_m;

    gp8_port i_gp8_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .mode_i(mode_i), .tmr_i(tmr_i), .tmr_o(tmr_o), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    gp8_board i_gp8_board (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_i(ext), .pin_i(pin_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] x);
        total_checks++;
        if (g !== x) begin
            fails++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // single classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        if (ack_o !== 1'b0 || n >= 20) begin
            fails++;
            tally_and_finish();
        end
    endtask

    initial begin
        {rst_i, sel_i, cyc_i, stb_i, we_i} = 5'h18;
        {adr_i, dat_i, ext, tmr_i} = '0;
        mode_i = gp8_pkg::GP8_RUN;
        r = 16'hB1F3;
        {fails, total_checks, lat_m, dir_m} = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        ext <= 8'h5A;
        chk("oe_rst", pin_oe_o, 8'h00);
        wb(1'b0, `GP8_ADDR_LATCH, 8'h00);
        chk("rd_rst", q, 8'h5A);
        wb(1'b0, `GP8_ADDR_DIR, 8'h00);
        chk("dir_rd", q, `GP8_DIR_READBACK);
        wb(1'b0, 16'h1234, 8'h00);
        chk("unmapped", q, `GP8_UNMAPPED_READ);
        // ----------------------------------------
        // random latch, direction and board levels
        // ----------------------------------------
        for (int i = 0; i < 40; i++) begin
            r = nx(r);
            ext <= r[15:8];
            wb(1'b1, `GP8_ADDR_DIR, r[7:0]);
            dir_m = r[7:0];
            r = nx(r);
            sel_i <= r[9:9];
            wb(1'b1, `GP8_ADDR_LATCH, r[7:0]);
            if (r[9]) lat_m = r[7:0];
            sel_i <= 1'b1;
            wb(1'b0, `GP8_ADDR_LATCH, 8'h00);
            e = 8'((lat_m & dir_m) | (ext & ~dir_m));
            chk("rd", q, e);
            chk("oe", pin_oe_o, 8'(dir_m));
            chk("drive", pin_o & pin_oe_o, 8'(lat_m & dir_m));
            chk("cap", {3'h0, tmr_o}, {3'h0, e[3], e[4], e[5], e[6], e[0]});
        end
        wb(1'b1, `GP8_ADDR_DIR, 8'h00);
        // compare outputs override inputs, all enable mixes
        for (int k = 0; k < 16; k++) begin
            tmr_i <= 4'(k);
            repeat (3) @(posedge clk_i);
            chk("ov_oe", pin_oe_o, 8'({k[2], k[3], 1'b0}));
            chk("ov_o", pin_o & pin_oe_o, 8'({k[2] & k[0], k[3] & k[1], 1'b0}));
        end
        tmr_i <= '0;
        wb(1'b1, `GP8_ADDR_DIR, 8'hFF);
        wb(1'b1, `GP8_ADDR_LATCH, 8'hAA);
        // overrides with every direction bit set, readback still the latch
        tmr_i <= 4'hC;
        wb(1'b0, `GP8_ADDR_LATCH, 8'h00);
        chk("ov_oe1", pin_oe_o, 8'hFF);
        chk("ov_dir1", pin_o, 8'hA8);
        chk("ov_rd", q, 8'hAA);
        tmr_i <= '0;
        repeat (2) @(posedge clk_i);
        mode_i <= gp8_pkg::GP8_HOLD;
        wb(1'b1, `GP8_ADDR_LATCH, 8'h55);
        chk("hold", pin_o, 8'hAA);
        mode_i <= gp8_pkg::GP8_FLOAT;
        repeat (2) @(posedge clk_i);
        chk("float", pin_oe_o, 8'h00);
        mode_i <= gp8_pkg::GP8_RUN;
        repeat (2) @(posedge clk_i);
        chk("run", pin_o, 8'h55);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("oe_rst2", pin_oe_o, 8'h00);
        wb(1'b1, `GP8_ADDR_DIR, 8'hFF);
        wb(1'b0, `GP8_ADDR_LATCH, 8'h00);
        chk("lat_rst2", q, `GP8_LATCH_RESET);
        tally_and_finish();
    end
endmodule
`default_nettype wire
